// *** verilog/ftf_pkg.sv ***
// ****************************************
// Shared constants and types
// ****************************************
package ftf_pkg;

	// ****************************************
	// Serial frame layout
	// ****************************************
	localparam logic [2:0] FTF_CMD_READ = 3'h2; // Read command code
	localparam logic [2:0] FTF_CMD_WRITE = 3'h4; // Write command code
	localparam logic [3:0] FTF_FRAME_LAST = 4'hf; // Index of last bit in a frame
	localparam int FTF_CMD_MSB = 15; // Command field top bit
	localparam int FTF_ADDR_MSB = 12; // Address field top bit

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [4:0] FTF_ADDR_TRIM = 5'h02; // Bias trim amount
	localparam logic [4:0] FTF_ADDR_EN = 5'h03; // Per-axis trim enables
	localparam logic [4:0] FTF_ADDR_THR = 5'h06; // field_threshold_config
	localparam logic [4:0] FTF_ADDR_STAT = 5'h1b; // field_alarm_status

	// ****************************************
	// Field positions
	// ****************************************
	localparam int FTF_EN_X_BIT = 0; // X trim enable
	localparam int FTF_EN_Y_BIT = 1; // Y trim enable
	localparam int FTF_THR_LOW_LSB = 5; // Low code, bits 7:5
	localparam int FTF_THR_HIGH_LSB = 2; // High code, bits 4:2
	localparam int FTF_STAT_HIGH_BIT = 7; // High-field flag
	localparam int FTF_STAT_LOW_BIT = 6; // Low-field flag
	localparam int FTF_STAT_P1_BIT = 3; // Partial low indication one
	localparam int FTF_STAT_P2_BIT = 2; // Partial low indication two

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [7:0] FTF_RST_TRIM = 8'h00; // No bias reduction
	localparam logic [1:0] FTF_RST_EN = 2'h0; // Both axes untrimmed
	localparam logic [2:0] FTF_RST_LOW_CODE = 3'h0; // Lowest low threshold
	localparam logic [2:0] FTF_RST_HIGH_CODE = 3'h7; // Highest high threshold

	// ****************************************
	// Field thresholds in mT
	// ****************************************
	localparam logic [7:0] FTF_HYST_MT = 8'h06; // Rise minus fall point
	localparam logic [7:0] FTF_RISE_MT [8] = '{8'h1a, 8'h29, 8'h38, 8'h46,
		8'h54, 8'h62, 8'h70, 8'h7e}; // Rising switch points per code

	// Serial engine states
	typedef enum logic [1:0] {FTF_IDLE, FTF_SHIFT, FTF_DONE} ftf_spi_state_t;

	// Rising switch point of a code
	function automatic logic [7:0] ftf_rise_mt(input logic [2:0] code);
		ftf_rise_mt = FTF_RISE_MT[code];
	endfunction

	// Falling switch point sits one hysteresis below
	function automatic logic [7:0] ftf_fall_mt(input logic [2:0] code);
		ftf_fall_mt = FTF_RISE_MT[code] - FTF_HYST_MT;
	endfunction

endpackage

// *** verilog/ftf_flag_if.sv ***
`timescale 1ns/10ps
// ****************************************
// Comparator carrier
// ****************************************
interface ftf_flag_if;
	logic [7:0] field; // Field magnitude in mT
	logic [2:0] code; // Threshold code
	logic flag; // Hysteretic flag
	modport ctrl (output field, output code, input flag);
	modport cmp (input field, input code, output flag);
endinterface

// *** verilog/ftf_field_flag.sv ***
`timescale 1ns/10ps
// ****************************************
// One hysteretic field comparator
// ****************************************
module ftf_field_flag
	import ftf_pkg::*;
#(
	parameter bit HIGH_SIDE = 1'b1 // 1: flag above, 0: flag below
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	ftf_flag_if.cmp fl
);

	typedef struct packed {
		logic flag; // Current flag level
	} ftf_cmp_state_t;

	ftf_cmp_state_t st; // Registered state
	ftf_cmp_state_t next_st; // Next state
	logic [7:0] rise; // Rising switch point
	logic [7:0] fall; // Falling switch point

	// Switch points follow the code at once, no ordering check
	always_comb begin
		rise = ftf_rise_mt(fl.code);
		fall = ftf_fall_mt(fl.code);
		next_st = st;
		if (HIGH_SIDE) begin
			// Set above rising point, clear below falling point
			if (!st.flag && fl.field > rise) begin
				next_st.flag = 1'b1;
			end else if (st.flag && fl.field < fall) begin
				next_st.flag = 1'b0;
			end
		end else begin
			// Set below falling point, clear above rising point
			if (!st.flag && fl.field < fall) begin
				next_st.flag = 1'b1;
			end else if (st.flag && fl.field > rise) begin
				next_st.flag = 1'b0;
			end
		end
	end

	// State register, flags start cleared
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign fl.flag = st.flag;

endmodule

// *** verilog/ftf_top.sv ***
`timescale 1ns/10ps
// ****************************************
// Field trim and threshold flags
// ****************************************

module ftf_top
	import ftf_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	input wire logic [7:0] field_mt_i,
	input wire logic [13:0] angle_i,
	output logic [13:0] angle_o,
	output logic field_low_flag_o,
	output logic field_high_flag_o,
	output logic [7:0] bias_trim_amount_o,
	output logic trim_x_enable_o,
	output logic trim_y_enable_o,
	output logic [7:0] trim_x_reduction_o,
	output logic [7:0] trim_y_reduction_o
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		ftf_spi_state_t spi_state; // Serial engine phase
		logic sclk_q; // Serial clock of last cycle
		logic [3:0] bit_cnt; // Bits taken in this frame
		logic [15:0] rx_sh; // Incoming frame
		logic [15:0] tx_sh; // Outgoing frame
		logic [7:0] resp; // Byte owed to next frame
		logic [7:0] trim_amt; // Bias trim amount
		logic [1:0] trim_en; // Y and X trim enables
		logic [2:0] low_code; // Low threshold code
		logic [2:0] high_code; // High threshold code
		logic [13:0] angle; // Angle passed through
		logic low_d; // Low flag one cycle back
		logic [7:0] trim_x; // X reduction to analog side
		logic [7:0] trim_y; // Y reduction to analog side
	} ftf_state_t;

	ftf_state_t st; // Registered state
	ftf_state_t next_st; // Next state
	logic [1:0] flags; // Bit 1 high flag, bit 0 low flag
	logic sclk_rise; // Serial clock rose
	logic sclk_fall; // Serial clock fell
	logic [15:0] frame; // Completed frame
	logic [2:0] cmd; // Frame command
	logic [4:0] addr; // Frame address
	logic [7:0] wval; // Frame value

	// ****************************************
	// Register read decode
	// ****************************************
	// Readable view of any address; unmapped addresses read zero
	function automatic logic [7:0] read_reg(input logic [4:0] a, input ftf_state_t s,
		input logic [1:0] f);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			FTF_ADDR_TRIM: begin
				r = s.trim_amt;
			end
			FTF_ADDR_EN: begin
				r[FTF_EN_X_BIT] = s.trim_en[FTF_EN_X_BIT];
				r[FTF_EN_Y_BIT] = s.trim_en[FTF_EN_Y_BIT];
			end
			FTF_ADDR_THR: begin
				r[FTF_THR_LOW_LSB +: 3] = s.low_code;
				r[FTF_THR_HIGH_LSB +: 3] = s.high_code;
			end
			FTF_ADDR_STAT: begin
				r[FTF_STAT_HIGH_BIT] = f[1];
				r[FTF_STAT_LOW_BIT] = f[0];
				// Partial indications: both are not low now, since the caller passes next_st whose low_d is the current low flag
				r[FTF_STAT_P1_BIT] = ~f[0];
				r[FTF_STAT_P2_BIT] = ~s.low_d;
			end
			default: begin
				r = 8'h00;
			end
		endcase
		read_reg = r;
	endfunction

	// ****************************************
	// Field comparators
	// ****************************************
	// Two comparators, low side (g 0) and high side (g 1), each with its own code
	for (genvar g = 0; g < 2; g++) begin : gen_cmp
		ftf_flag_if fl ();
		assign fl.field = field_mt_i;
		// Codes feed freely; low above high is allowed
		assign fl.code = (g == 1) ? st.high_code : st.low_code;
		assign flags[g] = fl.flag;
		ftf_field_flag #(
			.HIGH_SIDE(g == 1)
		) u_cmp (
			.clk_i(clk_i),
			.sys_rst_i(sys_rst_i),
			.fl(fl)
		);
	end

	// ****************************************
	// Frame fields
	// ****************************************
	always_comb begin
		frame = {st.rx_sh[14:0], spi_mosi_i};
		cmd = frame[FTF_CMD_MSB -: 3];
		addr = frame[FTF_ADDR_MSB -: 5];
		wval = frame[7:0];
		sclk_rise = spi_sclk_i && !st.sclk_q;
		sclk_fall = !spi_sclk_i && st.sclk_q;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.sclk_q = spi_sclk_i;
		// Angle passes unchanged, flags never touch it
		next_st.angle = angle_i;
		next_st.low_d = flags[0];
		// Reduction applied to each enabled axis by the same amount
		next_st.trim_x = st.trim_en[FTF_EN_X_BIT] ? st.trim_amt : 8'h00;
		next_st.trim_y = st.trim_en[FTF_EN_Y_BIT] ? st.trim_amt : 8'h00;
		if (spi_cs_n_i) begin
			// Deselected: preload answer so first bit is ready at select
			next_st.spi_state = FTF_IDLE;
			next_st.bit_cnt = 4'h0;
			next_st.tx_sh = {st.resp, 8'h00};
		end else begin
			case (st.spi_state)
				FTF_IDLE: begin
					next_st.spi_state = FTF_SHIFT;
				end
				FTF_SHIFT: begin
					// Data taken on rising edge, driven on falling edge
					if (sclk_rise) begin
						next_st.rx_sh = frame;
						next_st.bit_cnt = st.bit_cnt + 4'h1;
						if (st.bit_cnt == FTF_FRAME_LAST) begin
							next_st.spi_state = FTF_DONE;
							if (cmd == FTF_CMD_WRITE) begin
								// Writes land only in mapped fields
								case (addr)
									FTF_ADDR_TRIM: begin
										next_st.trim_amt = wval;
									end
									FTF_ADDR_EN: begin
										next_st.trim_en = wval[1:0];
									end
									FTF_ADDR_THR: begin
										next_st.low_code = wval[FTF_THR_LOW_LSB +: 3];
										next_st.high_code = wval[FTF_THR_HIGH_LSB +: 3];
									end
									default: begin
										next_st.trim_amt = st.trim_amt;
									end
								endcase
							end
							// Answer owed to next frame, reflecting any write
							if (cmd == FTF_CMD_READ || cmd == FTF_CMD_WRITE) begin
								next_st.resp = read_reg(addr, next_st, flags);
							end else begin
								next_st.resp = 8'h00;
							end
						end
					end else if (sclk_fall) begin
						next_st.tx_sh = {st.tx_sh[14:0], 1'b0};
					end
				end
				FTF_DONE: begin
					// Extra clocks ignored until deselect
					next_st.spi_state = FTF_DONE;
				end
				default: begin
					next_st.spi_state = FTF_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Reset gives zero trim so the raw error curve can be taken
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.spi_state <= FTF_IDLE;
			st.sclk_q <= 1'b0;
			st.trim_amt <= FTF_RST_TRIM;
			st.trim_en <= FTF_RST_EN;
			st.low_code <= FTF_RST_LOW_CODE;
			st.high_code <= FTF_RST_HIGH_CODE;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Drive the data line only while selected
	assign spi_miso_oe_o = !spi_cs_n_i;
	assign spi_miso_o = st.tx_sh[15];
	assign angle_o = st.angle;
	assign field_low_flag_o = flags[0];
	assign field_high_flag_o = flags[1];
	assign bias_trim_amount_o = st.trim_amt;
	assign trim_x_enable_o = st.trim_en[FTF_EN_X_BIT];
	assign trim_y_enable_o = st.trim_en[FTF_EN_Y_BIT];
	assign trim_x_reduction_o = st.trim_x;
	assign trim_y_reduction_o = st.trim_y;

endmodule

// *** sim/ftf_top_checker.sv ***
`timescale 1ns/10ps
// ****
// Port checker
// ****
module ftf_top_checker (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_miso_oe_o,
	input wire logic [7:0] field_mt_i,
	input wire logic [13:0] angle_i,
	input wire logic [13:0] angle_o,
	input wire logic field_low_flag_o,
	input wire logic field_high_flag_o,
	input wire logic [7:0] bias_trim_amount_o,
	input wire logic trim_x_enable_o,
	input wire logic trim_y_enable_o,
	input wire logic [7:0] trim_x_reduction_o,
	input wire logic [7:0] trim_y_reduction_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Reset leaves flags and trim clear
	a_reset_clears: assert property ($fell(sys_rst_i) |->
		!field_low_flag_o && !field_high_flag_o && bias_trim_amount_o == 8'h00
		&& !trim_x_enable_o && !trim_y_enable_o) else $error("reset left state");
	a_angle_passes: assert property (!$past(sys_rst_i) |-> angle_o == $past(angle_i))
		else $error("angle altered");
	a_x_reduction: assert property (!$past(sys_rst_i) |->
		trim_x_reduction_o == ($past(trim_x_enable_o) ? $past(bias_trim_amount_o) : 8'h00))
		else $error("x reduction wrong");
	a_y_reduction: assert property (!$past(sys_rst_i) |->
		trim_y_reduction_o == ($past(trim_y_enable_o) ? $past(bias_trim_amount_o) : 8'h00))
		else $error("y reduction wrong");
	// Settings may only move while a frame is open
	a_trim_framed: assert property (!$past(sys_rst_i) &&
		$changed({bias_trim_amount_o, trim_x_enable_o, trim_y_enable_o}) |-> !spi_cs_n_i)
		else $error("trim moved outside frame");
	// Any code: rising point at least 26, falling point at most 120
	a_high_sets: assert property ($rose(field_high_flag_o) |-> $past(field_mt_i) > 8'h1a)
		else $error("high flag set too low");
	a_low_sets: assert property ($rose(field_low_flag_o) |-> $past(field_mt_i) < 8'h78)
		else $error("low flag set too high");
	a_high_clears: assert property (!$past(sys_rst_i) && $fell(field_high_flag_o) |->
		$past(field_mt_i) < 8'h78) else $error("high flag cleared too high");
	// Data line driven exactly while the host selects us
	a_oe_follows_cs: assert property (spi_miso_oe_o == !spi_cs_n_i)
		else $error("miso enable wrong");
	c_both_flags: cover property (field_low_flag_o && field_high_flag_o);
	c_low_rise: cover property ($rose(field_low_flag_o));
	c_high_rise: cover property ($rose(field_high_flag_o));
	c_both_trim: cover property (trim_x_reduction_o != 8'h00 && trim_y_reduction_o != 8'h00);
endmodule
bind ftf_top ftf_top_checker chk (.clk_i, .sys_rst_i, .spi_cs_n_i, .spi_miso_oe_o,
	.field_mt_i, .angle_i, .angle_o, .field_low_flag_o, .field_high_flag_o,
	.bias_trim_amount_o, .trim_x_enable_o, .trim_y_enable_o, .trim_x_reduction_o,
	.trim_y_reduction_o);

// *** sim/ftf_spi_host.sv ***
`timescale 1ns/10ps
// ****
// SPI host model, mode 0
// ****
module ftf_spi_host (
	input wire logic clk_i,
	input wire logic miso_i,
	output logic cs_n_o = 1'b1,
	output logic sclk_o = 1'b0,
	output logic mosi_o = 1'b0
);
	// One frame MSB first; long phases leave room for sclk sampling
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		int i;
		r = 16'h0000;
		@(posedge clk_i) cs_n_o <= 1'b0;
		for (i = 15; i >= 0; i--) begin
			@(posedge clk_i) mosi_o <= w[i];
			repeat (3) @(posedge clk_i);
			@(posedge clk_i) begin
				sclk_o <= 1'b1;
				r[i] = miso_i; // Taken on the rise
			end
			repeat (3) @(posedge clk_i);
			@(posedge clk_i) sclk_o <= 1'b0;
		end
		repeat (3) @(posedge clk_i);
		@(posedge clk_i) begin
			cs_n_o <= 1'b1;
			mosi_o <= ~mosi_o; // Released line keeps no stale bit
		end
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// *** sim/ftf_top_test.sv ***
`timescale 1ns/10ps
// ****
// Bench top
// ****
module ftf_top_test
	import ftf_pkg::*;
;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
	logic [7:0] field_mt_i = 8'h00;
	logic [13:0] angle_i = 14'h0000, angle_o;
	logic field_low_flag_o, field_high_flag_o, trim_x_enable_o, trim_y_enable_o;
	logic [7:0] bias_trim_amount_o, trim_x_reduction_o, trim_y_reduction_o;
	logic [15:0] rsp; // Last answer seen
	logic elo, ehi; // Expected flags
	int fails = 0, compares = 0, cycles = 0;
	// Rising points per code; falling is 6 below
	logic [7:0] rtab [8] = '{8'h1a, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7e};
	logic [7:0] offs [4] = '{8'h00, 8'h01, 8'hfa, 8'hf9}; // Edges of each band
	ftf_top uut (.clk_i, .sys_rst_i, .spi_cs_n_i, .spi_sclk_i, .spi_mosi_i, .spi_miso_o,
		.spi_miso_oe_o, .field_mt_i, .angle_i, .angle_o, .field_low_flag_o, .field_high_flag_o,
		.bias_trim_amount_o, .trim_x_enable_o, .trim_y_enable_o, .trim_x_reduction_o,
		.trim_y_reduction_o);
	ftf_spi_host host (.clk_i, .miso_i(spi_miso_o), .cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i),
		.mosi_o(spi_mosi_i));
	always #12.5 clk_i = ~clk_i;
	// Fresh angle each cycle; hang guard
	always @(posedge clk_i) begin
		angle_i <= 14'($urandom);
		cycles++;
		if (cycles == 30000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		host.xfer({FTF_CMD_WRITE, a, v}, rsp);
	endtask
	// Answer arrives in the frame after the request
	task automatic rc(input logic [4:0] a, input logic [7:0] exp, input string what);
		host.xfer({FTF_CMD_READ, a, 8'h00}, rsp);
		host.xfer({FTF_CMD_READ, a, 8'h00}, rsp);
		chk(what, exp, rsp[15:8]);
	endtask
	function automatic logic [7:0] trim_for_k(input int k);
		return 8'(32'h102 * (k - 1) / k);
	endfunction
	// Flag model: strict compares, hold inside the band
	task automatic set_field(input logic [7:0] f, input logic [2:0] lc, input logic [2:0] hc);
		@(posedge clk_i) field_mt_i <= f;
		ehi = (f > rtab[hc]) ? 1'b1 : (f < rtab[hc] - 8'h06) ? 1'b0 : ehi;
		elo = (f < rtab[lc] - 8'h06) ? 1'b1 : (f > rtab[lc]) ? 1'b0 : elo;
		repeat (2) @(posedge clk_i);
		chk("high pin", {7'h00, ehi}, {7'h00, field_high_flag_o});
		chk("low pin", {7'h00, elo}, {7'h00, field_low_flag_o});
	endtask
	task automatic give_verdict();
		$display("Compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		logic [7:0] t, f;
		logic [1:0] e;
		int i, j, c;
		void'($urandom(58));
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rc(FTF_ADDR_THR, 8'h1c, "threshold reset");
		rc(FTF_ADDR_TRIM, 8'h00, "trim reset");
		rc(FTF_ADDR_EN, 8'h00, "enable reset");
		rc(5'h1f, 8'h00, "unmapped");
		// Unknown command: no write, and the next answer is zero
		host.xfer({FTF_CMD_READ, FTF_ADDR_THR, 8'h00}, rsp);
		host.xfer({3'h7, FTF_ADDR_THR, 8'hff}, rsp);
		chk("before unknown", 8'h1c, rsp[15:8]);
		host.xfer({FTF_CMD_READ, FTF_ADDR_THR, 8'h00}, rsp);
		chk("unknown command", 8'h00, rsp[15:8]);
		rc(FTF_ADDR_THR, 8'h1c, "threshold kept");
		$display("Done reset values");
		for (i = 0; i < 6; i++) begin
			t = (i == 0) ? trim_for_k(2) : (i == 1) ? 8'hff : 8'($urandom);
			e = 2'(i);
			wr(FTF_ADDR_TRIM, t);
			wr(FTF_ADDR_EN, {6'($urandom), e});
			chk("trim amount", t, bias_trim_amount_o);
			chk("enables", {6'h00, e}, {6'h00, trim_y_enable_o, trim_x_enable_o});
			chk("x reduction", e[0] ? t : 8'h00, trim_x_reduction_o);
			chk("y reduction", e[1] ? t : 8'h00, trim_y_reduction_o);
			rc(FTF_ADDR_TRIM, t, "trim readback");
			rc(FTF_ADDR_EN, {6'h00, e}, "enable readback");
		end
		// Mid-run reset must drop trim settings back to zero
		@(posedge clk_i) sys_rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("trim after reset", 8'h00, bias_trim_amount_o);
		chk("x after reset", 8'h00, trim_x_reduction_o);
		chk("y after reset", 8'h00, trim_y_reduction_o);
		$display("Done trim");
		for (c = 0; c < 8; c++) begin
			wr(FTF_ADDR_THR, {3'(c), 3'(7 - c), 2'h3});
			rc(FTF_ADDR_THR, {3'(c), 3'(7 - c), 2'h0}, "threshold readback");
			set_field(8'h00, 3'(c), 3'(7 - c));
			for (j = 0; j < 20; j++) begin
				f = rtab[j[0] ? c : 7 - c];
				f = f + ((j < 8) ? offs[j >> 1] : 8'($urandom_range(32'h12)) - 8'h09);
				set_field(f, 3'(c), 3'(7 - c));
			end
			rc(FTF_ADDR_STAT, {ehi, elo, 2'h0, ~elo, ~elo, 2'h0}, "status");
			chk("corrected low", {7'h00, elo}, {7'h00, ~(rsp[11] | rsp[10])});
		end
		$display("Done thresholds");
		give_verdict();
	end
endmodule
